/* src/ocr_pkg.sv */
package ocr_pkg;

  localparam int unsigned OCR_AW    = 8;
  localparam int unsigned OCR_DW    = 16;
  localparam int unsigned OCR_PW    = 16;
  localparam int unsigned OCR_TW    = 12;
  localparam int unsigned OCR_LW    = 12;
  localparam int unsigned OCR_CW    = 5;
  localparam int unsigned OCR_NCOEF = 15;

  // register byte offsets
  localparam logic [7:0] OCR_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] OCR_ADDR_STATUS = 8'h02;
  localparam logic [7:0] OCR_ADDR_MASK   = 8'h04;
  localparam logic [7:0] OCR_ADDR_FAULT  = 8'h06;
  localparam logic [7:0] OCR_ADDR_LEVEL  = 8'h08;
  localparam logic [7:0] OCR_ADDR_PRESS  = 8'h52;
  localparam logic [7:0] OCR_ADDR_TEMP   = 8'h62;
  localparam logic [7:0] OCR_ADDR_COEF0  = 8'h80;
  localparam logic [7:0] OCR_ADDR_COEFN  = 8'h9C;

  // clamp table
  localparam logic [6:0] OCR_HI_BASE_PCT = 7'h60;
  localparam logic [6:0] OCR_LO_BASE_PCT = 7'h04;
  localparam logic [6:0] OCR_HI_SAT_PCT  = 7'h46;
  localparam logic [6:0] OCR_LO_SAT_PCT  = 7'h1E;
  localparam logic [4:0] OCR_SAT_CODE    = 5'h1B;
  localparam logic [18:0] OCR_FULL_CODES = 19'h0_1000;
  localparam logic [18:0] OCR_FULL_PCT   = 19'h0_0064;

  typedef struct packed {
    logic       diag_en;
    logic [4:0] lo_code;
    logic [4:0] hi_code;
  } ocr_ctrl_t;

  localparam ocr_ctrl_t OCR_CTRL_RST  = 11'h400;
  localparam logic [11:0] OCR_LEVEL_RST = 12'h0A3;

  typedef struct packed {
    logic ecc;
    logic over_volt;
    logic under_volt;
    logic bridge;
  } ocr_fault_t;

  typedef struct packed {
    logic       clamp_lo;
    logic       clamp_hi;
    ocr_fault_t fault;
  } ocr_evt_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ocr_bus_req_t;

endpackage : ocr_pkg

/* src/ocr_output_clamp.sv */
// Operation
// - pressure Q1.15 at 0x52, temperature Q1.11 at 0x62
// - coefficients stored as signed 16-bit Q1.15
// - output level proportional to compensated bridge signal
// - digital clamps bound the linear output range
// - clamp codes below 27 map 96-n and 4+n percent, higher codes 70 and 30 percent
// - enabled diagnostics with fault release the output
// - levels beyond clamps never carry measurements
`timescale 1ns/10ps
module ocr_output_clamp (
  input  wire logic                 CLOCK,
  input  wire logic                 RSTN,
  input  wire ocr_pkg::ocr_bus_req_t BUS,
  output logic [15:0]               RDATA,
  input  wire logic                 PRESS_VALID,
  input  wire logic [15:0]          PRESS_DATA,
  input  wire logic                 TEMP_VALID,
  input  wire logic [11:0]          TEMP_DATA,
  input  wire ocr_pkg::ocr_fault_t  FAULT_PINS,
  input  wire logic [3:0]           COEFF_SEL,
  output logic [15:0]               COEFF_DATA,
  output logic [11:0]               OUT_LEVEL,
  output logic                      OUT_OE_N,
  output logic                      IRQ
);
  import ocr_pkg::*;

  typedef struct packed {
    ocr_ctrl_t        ctrl;
    ocr_evt_t         status;
    ocr_evt_t         mask;
    logic [15:0]      press;
    logic [11:0]      temp;
    logic [14:0][15:0] coef;
    ocr_fault_t       sync1;
    ocr_fault_t       sync2;
    ocr_fault_t       sync3;
    ocr_fault_t       fault;
    logic [15:0]      rdata;
    logic [15:0]      coef_q;
    logic [11:0]      level;
    logic             oe_n;
    logic             irq;
  } ocr_state_t;

  ocr_state_t state_r;
  ocr_state_t state_nxt;
  logic [11:0] hi_lvl;
  logic [11:0] lo_lvl;
  logic [11:0] mapped;
  logic        flt_any;

  // percent of supply to output code
  function automatic logic [11:0] pct_to_code(input logic [6:0] pct);
    logic [18:0] prod;
    prod = {12'h000, pct} * OCR_FULL_CODES;
    return 12'(prod / OCR_FULL_PCT);
  endfunction : pct_to_code

  // clamp code to percent, saturating codes
  function automatic logic [6:0] clamp_pct(input logic [4:0] code, input logic high);
    logic [6:0] pct;
    if (code >= OCR_SAT_CODE) begin
      pct = high ? OCR_HI_SAT_PCT : OCR_LO_SAT_PCT;
    end else begin
      pct = high ? OCR_HI_BASE_PCT - {2'b00, code} : OCR_LO_BASE_PCT + {2'b00, code};
    end
    return pct;
  endfunction : clamp_pct

  // signed Q1.15 to offset-binary output code
  function automatic logic [11:0] map_press(input logic [15:0] p);
    return {~p[15], p[14:4]};
  endfunction : map_press

  function automatic logic coef_hit(input logic [7:0] a);
    return (a >= OCR_ADDR_COEF0) && (a <= OCR_ADDR_COEFN) && !a[0];
  endfunction : coef_hit

  function automatic logic [3:0] coef_idx(input logic [7:0] a);
    logic [7:0] d;
    d = a - OCR_ADDR_COEF0;
    return d[4:1];
  endfunction : coef_idx

  assign hi_lvl  = pct_to_code(clamp_pct(state_r.ctrl.hi_code, 1'b1));
  assign lo_lvl  = pct_to_code(clamp_pct(state_r.ctrl.lo_code, 1'b0));
  assign mapped  = map_press(state_r.press);
  assign flt_any = |state_r.fault;

  always_comb begin
    ocr_evt_t set_ev;
    ocr_evt_t clr_ev;
    state_nxt = state_r;
    set_ev    = '0;
    clr_ev    = '0;

    // compensated readings from the datapath
    if (PRESS_VALID) begin
      state_nxt.press = PRESS_DATA;
    end
    if (TEMP_VALID) begin
      state_nxt.temp = TEMP_DATA;
    end

    // fault pin filter, change taken once stages two and three agree
    state_nxt.sync1 = FAULT_PINS;
    state_nxt.sync2 = state_r.sync1;
    state_nxt.sync3 = state_r.sync2;
    for (int i = 0; i < 4; i++) begin
      if (state_r.sync2[i] == state_r.sync3[i]) begin
        state_nxt.fault[i] = state_r.sync3[i];
      end
    end
    set_ev.fault = state_nxt.fault & ~state_r.fault;

    // clamping of the mapped level
    if (mapped > hi_lvl) begin
      state_nxt.level = hi_lvl;
      set_ev.clamp_hi = 1'b1;
    end else if (mapped < lo_lvl) begin
      state_nxt.level = lo_lvl;
      set_ev.clamp_lo = 1'b1;
    end else begin
      state_nxt.level = mapped;
    end

    // diagnostics release the pin
    state_nxt.oe_n = state_r.ctrl.diag_en && flt_any;

    // register writes
    if (BUS.wr) begin
      if (BUS.addr == OCR_ADDR_CTRL) begin
        state_nxt.ctrl = BUS.wdata[10:0];
      end else if (BUS.addr == OCR_ADDR_STATUS) begin
        clr_ev = BUS.wdata[5:0];
      end else if (BUS.addr == OCR_ADDR_MASK) begin
        state_nxt.mask = BUS.wdata[5:0];
      end else if (coef_hit(BUS.addr)) begin
        state_nxt.coef[coef_idx(BUS.addr)] = BUS.wdata;
      end
    end

    // sticky events, set wins over clear
    state_nxt.status = (state_r.status & ~clr_ev) | set_ev;
    state_nxt.irq    = |(state_nxt.status & state_nxt.mask);

    // register reads, data in the following cycle
    state_nxt.rdata = '0;
    if (BUS.rd) begin
      if (BUS.addr == OCR_ADDR_CTRL) begin
        state_nxt.rdata = {5'h00, state_r.ctrl};
      end else if (BUS.addr == OCR_ADDR_STATUS) begin
        state_nxt.rdata = {10'h000, state_r.status};
      end else if (BUS.addr == OCR_ADDR_MASK) begin
        state_nxt.rdata = {10'h000, state_r.mask};
      end else if (BUS.addr == OCR_ADDR_FAULT) begin
        state_nxt.rdata = {12'h000, state_r.fault};
      end else if (BUS.addr == OCR_ADDR_LEVEL) begin
        state_nxt.rdata = {3'h0, state_r.oe_n, state_r.level};
      end else if (BUS.addr == OCR_ADDR_PRESS) begin
        state_nxt.rdata = state_r.press;
      end else if (BUS.addr == OCR_ADDR_TEMP) begin
        state_nxt.rdata = {4'h0, state_r.temp};
      end else if (coef_hit(BUS.addr)) begin
        state_nxt.rdata = state_r.coef[coef_idx(BUS.addr)];
      end
    end

    // coefficient port to the compensation datapath
    if (COEFF_SEL < 4'(OCR_NCOEF)) begin
      state_nxt.coef_q = state_r.coef[COEFF_SEL];
    end else begin
      state_nxt.coef_q = '0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      state_r       <= '0;
      state_r.ctrl  <= OCR_CTRL_RST;
      state_r.level <= OCR_LEVEL_RST;
      state_r.oe_n  <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign RDATA      = state_r.rdata;
  assign COEFF_DATA = state_r.coef_q;
  assign OUT_LEVEL  = state_r.level;
  assign OUT_OE_N   = state_r.oe_n;
  assign IRQ        = state_r.irq;

  // checks
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);

  sequence s_coef_write;
    BUS.wr && coef_hit(BUS.addr);
  endsequence

  sequence s_coef_readback;
    BUS.rd && !BUS.wr && (BUS.addr == $past(BUS.addr));
  endsequence

  sequence s_bridge_drop;
    $fell(FAULT_PINS.bridge) ##1 !FAULT_PINS.bridge [*3];
  endsequence

  chk_press_read: assert property (
    BUS.rd && BUS.addr == OCR_ADDR_PRESS |=> RDATA == $past(state_r.press))
    else $error("pressure read mismatch");

  chk_temp_read: assert property (
    BUS.rd && BUS.addr == OCR_ADDR_TEMP |=> RDATA == {4'h0, $past(state_r.temp)})
    else $error("temperature read mismatch");

  chk_coef_store: assert property (
    s_coef_write ##1 s_coef_readback |=> RDATA == $past(BUS.wdata, 2))
    else $error("coefficient not stored");

  chk_linear_map: assert property (
    RSTN && mapped <= hi_lvl && mapped >= lo_lvl |=> OUT_LEVEL == $past(mapped))
    else $error("output not proportional");

  chk_level_range: assert property (
    OUT_LEVEL <= $past(hi_lvl) && OUT_LEVEL >= $past(lo_lvl))
    else $error("level beyond clamps");

  chk_high_clamp: assert property (
    mapped > hi_lvl |=> OUT_LEVEL == $past(hi_lvl))
    else $error("high clamp not applied");

  chk_low_clamp: assert property (
    mapped < lo_lvl |=> OUT_LEVEL == $past(lo_lvl))
    else $error("low clamp not applied");

  chk_clamp_codes: assert property (
    state_r.ctrl.hi_code >= OCR_SAT_CODE |-> hi_lvl == pct_to_code(OCR_HI_SAT_PCT))
    else $error("clamp code decode wrong");

  chk_fault_hiz: assert property (
    state_r.ctrl.diag_en && flt_any |=> OUT_OE_N)
    else $error("output not released on fault");

  chk_fault_filter: assert property (
    $rose(FAULT_PINS.ecc) ##1 FAULT_PINS.ecc [*3] |-> ##[0:1] state_r.fault.ecc)
    else $error("fault filter too slow");

  // clamp decode and limits
  chk_lo_code_sat: assert property (
    state_r.ctrl.lo_code >= OCR_SAT_CODE |-> lo_lvl == pct_to_code(OCR_LO_SAT_PCT))
    else $error("low clamp saturation wrong");

  chk_hi_code_step: assert property (
    state_r.ctrl.hi_code < OCR_SAT_CODE
      |-> hi_lvl == pct_to_code(OCR_HI_BASE_PCT - 7'(state_r.ctrl.hi_code)))
    else $error("high clamp step wrong");

  chk_lo_code_step: assert property (
    state_r.ctrl.lo_code < OCR_SAT_CODE
      |-> lo_lvl == pct_to_code(OCR_LO_BASE_PCT + 7'(state_r.ctrl.lo_code)))
    else $error("low clamp step wrong");

  chk_limit_order: assert property (
    lo_lvl < hi_lvl)
    else $error("clamp limits crossed");

  // faults, events and interrupt
  chk_oe_driven: assert property (
    !(state_r.ctrl.diag_en && flt_any) |=> !OUT_OE_N)
    else $error("output released without fault");

  chk_fault_drop: assert property (
    s_bridge_drop |-> ##[0:1] !state_r.fault.bridge)
    else $error("fault filter slow to clear");

  chk_fault_event: assert property (
    ((state_r.fault & ~$past(state_r.fault)) & ~state_r.status.fault) == 4'h0)
    else $error("fault rise not flagged");

  chk_status_sticky: assert property (
    !(BUS.wr && BUS.addr == OCR_ADDR_STATUS)
      |=> (state_r.status & $past(state_r.status)) == $past(state_r.status))
    else $error("status bit lost without clear");

  chk_irq_level: assert property (
    IRQ == |(state_r.status & state_r.mask))
    else $error("interrupt level wrong");

  chk_mask_write: assert property (
    BUS.wr && BUS.addr == OCR_ADDR_MASK |=> state_r.mask == $past(BUS.wdata[5:0]))
    else $error("mask write lost");

  chk_hi_flag: assert property (
    mapped > hi_lvl |=> state_r.status.clamp_hi)
    else $error("high clamp event missing");

  chk_lo_flag: assert property (
    mapped < lo_lvl |=> state_r.status.clamp_lo)
    else $error("low clamp event missing");

  // register and coefficient paths
  chk_read_idle: assert property (
    !BUS.rd |=> RDATA == 16'h0000)
    else $error("read data without read");

  chk_press_latch: assert property (
    PRESS_VALID |=> state_r.press == $past(PRESS_DATA))
    else $error("pressure not latched");

  chk_temp_latch: assert property (
    TEMP_VALID |=> state_r.temp == $past(TEMP_DATA))
    else $error("temperature not latched");

  chk_press_ro: assert property (
    BUS.wr && BUS.addr == OCR_ADDR_PRESS && !PRESS_VALID |=> $stable(state_r.press))
    else $error("pressure register written");

  chk_ctrl_write: assert property (
    BUS.wr && BUS.addr == OCR_ADDR_CTRL |=> state_r.ctrl == $past(BUS.wdata[10:0]))
    else $error("control write lost");

  chk_level_read: assert property (
    BUS.rd && BUS.addr == OCR_ADDR_LEVEL
      |=> RDATA == {3'h0, $past(state_r.oe_n), $past(state_r.level)})
    else $error("level read mismatch");

  chk_fault_read: assert property (
    BUS.rd && BUS.addr == OCR_ADDR_FAULT |=> RDATA == {12'h000, $past(state_r.fault)})
    else $error("fault read mismatch");

  chk_coef_read: assert property (
    BUS.rd && coef_hit(BUS.addr)
      |=> RDATA == $past(state_r.coef[coef_idx(BUS.addr)]))
    else $error("coefficient read mismatch");

  chk_coef_port: assert property (
    COEFF_SEL < 4'(OCR_NCOEF)
      |=> COEFF_DATA == $past(state_r.coef[COEFF_SEL]))
    else $error("coefficient port mismatch");

  chk_coef_zero: assert property (
    COEFF_SEL >= 4'(OCR_NCOEF) |=> COEFF_DATA == 16'h0000)
    else $error("coefficient port not zero");

endmodule : ocr_output_clamp

/* dv/ocr_calib_model.sv */
`timescale 1ns/10ps
module ocr_calib_model (
  input  wire logic [3:0]  idx,
  input  wire logic [15:0] fit,
  output logic [15:0]      stored
);
  logic signed [16:0] shifted;
  // fitted value in [-1,1), first-order term less one, then scaled by 1/16
  always_comb begin
    shifted = $signed({fit[15], fit}) - ((idx == 4'h1) ? 17'sh0_8000 : 17'sh0_0000);
    shifted = shifted >>> 4;
    stored  = shifted[15:0];
  end
endmodule : ocr_calib_model

/* dv/ocr_output_clamp_tb.sv */
`timescale 1ns/10ps
module ocr_output_clamp_tb;
  import ocr_pkg::*;
  logic         clock;
  logic         rstn;
  ocr_bus_req_t bus;
  logic [15:0]  rdata;
  logic         press_valid;
  logic [15:0]  press_data;
  logic         temp_valid;
  logic [11:0]  temp_data;
  ocr_fault_t   fault_pins;
  logic [3:0]   coeff_sel;
  logic [15:0]  coeff_data;
  logic [11:0]  out_level;
  logic         out_oe_n;
  logic         irq;
  logic [15:0]  fit;
  logic [15:0]  stored;
  logic [15:0]  lfsr;
  int           fails;
  int           checks_done;

  ocr_output_clamp DUT (.CLOCK(clock), .RSTN(rstn), .BUS(bus), .RDATA(rdata),
    .PRESS_VALID(press_valid), .PRESS_DATA(press_data), .TEMP_VALID(temp_valid),
    .TEMP_DATA(temp_data), .FAULT_PINS(fault_pins), .COEFF_SEL(coeff_sel),
    .COEFF_DATA(coeff_data), .OUT_LEVEL(out_level), .OUT_OE_N(out_oe_n), .IRQ(irq));
  ocr_calib_model cal (.idx(coeff_sel), .fit(fit), .stored(stored));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  function automatic logic [11:0] lim(input logic [4:0] c, input logic hi);
    int pct;
    if (hi) pct = (c >= 5'h1B) ? 70 : 96 - int'(c);
    else pct = (c >= 5'h1B) ? 30 : 4 + int'(c);
    return 12'((pct * 4096) / 100);
  endfunction : lim

  function automatic logic [15:0] exp_level(input logic [15:0] p, input logic [4:0] hc, lc);
    logic [11:0] m;
    m = {~p[15], p[14:4]};
    if (m > lim(hc, 1'b1)) m = lim(hc, 1'b1);
    if (m < lim(lc, 1'b0)) m = lim(lc, 1'b0);
    return {4'h0, m};
  endfunction : exp_level

  function automatic logic [15:0] exp_flags(input logic [15:0] p, input logic [4:0] hc, lc);
    logic [11:0] m;
    m = {~p[15], p[14:4]};
    return {10'h000, m < lim(lc, 1'b0), m > lim(hc, 1'b1), 4'h0};
  endfunction : exp_flags

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  task automatic cyc(input ocr_bus_req_t r);
    @(posedge clock);
    bus <= r;
    @(posedge clock);
    bus <= '0;
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    cyc('{a, d, 1'b1, 1'b0});
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    cyc('{a, 16'h0000, 1'b0, 1'b1});
    check(rdata, e);
  endtask : rd_chk

  task automatic wr_rd(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clock);
    bus <= '0;
    #1;
    check(rdata, d);
  endtask : wr_rd

  task automatic press(input logic [15:0] p);
    @(posedge clock);
    press_valid <= 1'b1;
    press_data  <= p;
    @(posedge clock);
    press_valid <= 1'b0;
    @(posedge clock);
    #1;
  endtask : press

  task automatic clamp_case(input logic [4:0] hc, lc, input logic [15:0] p);
    wr(OCR_ADDR_CTRL, {5'h00, 1'b1, lc, hc});
    press(p);
    check({4'h0, out_level}, exp_level(p, hc, lc));
    rd_chk(OCR_ADDR_LEVEL, exp_level(p, hc, lc));
    wr(OCR_ADDR_STATUS, 16'h0030);
    rd_chk(OCR_ADDR_STATUS, exp_flags(p, hc, lc));
    wr(OCR_ADDR_PRESS, ~p);
    rd_chk(OCR_ADDR_PRESS, p);
  endtask : clamp_case

  task automatic fault_case(input ocr_fault_t f, input logic en);
    @(posedge clock);
    fault_pins <= f;
    repeat (6) @(posedge clock);
    #1;
    check({15'h0000, out_oe_n}, {15'h0000, en});
    rd_chk(OCR_ADDR_FAULT, {12'h000, f});
    @(posedge clock);
    fault_pins <= '0;
    repeat (6) @(posedge clock);
    #1;
    check({15'h0000, out_oe_n}, 16'h0000);
  endtask : fault_case

  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    complete_run();
  end

  initial begin
    fails = 0;
    checks_done = 0;
    rstn = 1'b0;
    bus = '0;
    press_valid = 1'b0;
    press_data = 16'h0000;
    temp_valid = 1'b0;
    temp_data = 12'h000;
    fault_pins = '0;
    coeff_sel = 4'h0;
    fit = 16'h0000;
    lfsr = 16'h0024;
    repeat (12) @(posedge clock);
    rstn <= 1'b1;
    #1;
    check({4'h0, out_level}, 16'h00A3);
    check({14'h0000, out_oe_n, irq}, 16'h0000);
    rd_chk(OCR_ADDR_CTRL, 16'h0400);
    rd_chk(8'h40, 16'h0000);
    for (int c = 0; c < 32; c++) begin
      clamp_case(c[4:0], c[4:0], 16'h7FFF);
      clamp_case(c[4:0], c[4:0], 16'h8000);
    end
    repeat (20) begin
      lfsr = lfsr_next(lfsr);
      clamp_case(lfsr[4:0], lfsr[9:5], lfsr_next(lfsr));
    end
    @(posedge clock);
    temp_valid <= 1'b1;
    temp_data  <= lfsr[11:0];
    @(posedge clock);
    temp_valid <= 1'b0;
    rd_chk(OCR_ADDR_TEMP, {4'h0, lfsr[11:0]});
    for (int i = 0; i < 15; i++) begin
      lfsr = lfsr_next(lfsr);
      @(posedge clock);
      coeff_sel <= i[3:0];
      fit <= lfsr;
      #1;
      wr_rd(OCR_ADDR_COEF0 + 8'(2 * i), stored);
      check(coeff_data, stored);
    end
    @(posedge clock);
    coeff_sel <= 4'hF;
    @(posedge clock);
    #1;
    check(coeff_data, 16'h0000);
    rd_chk(8'h81, 16'h0000);
    wr(OCR_ADDR_CTRL, 16'h0400);
    press(16'h0000);
    wr(OCR_ADDR_STATUS, 16'h003F);
    wr(OCR_ADDR_MASK, 16'h000F);
    check({15'h0000, irq}, 16'h0000);
    for (int f = 0; f < 4; f++) begin
      fault_case(ocr_fault_t'(4'h1 << f), 1'b1);
      check({15'h0000, irq}, 16'h0001);
      rd_chk(OCR_ADDR_STATUS, 16'h0001 << f);
      wr(OCR_ADDR_STATUS, 16'h000F);
      check({15'h0000, irq}, 16'h0000);
    end
    wr(OCR_ADDR_CTRL, 16'h0000);
    fault_case(ocr_fault_t'(4'h1), 1'b0);
    complete_run();
  end
endmodule : ocr_output_clamp_tb
